// *** hw/omcs_top.sv ***
// Control and status logic of a pluggable optical module: two-wire slave,
// identification and diagnostic areas, transmit disable and fault latch.
// Assumes bus pins and status pins arrive asynchronously to i_sys_clk,
// live readings and the factory load port come from i_sys_clk logic.
`default_nettype none

module omcs_top (
  input wire logic i_sys_clk, // System clock, 25 MHz
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_clk_en, // Freezes all state while low
  input wire logic i_scl, // Bus clock from host
  input wire logic i_sda, // Bus data, wire level
  output logic o_sda_out, // Bus data drive value, always low
  output logic o_sda_oe_n, // Bus data enable, low pulls the wire
  input wire logic i_tx_disable, // Transmit disable pin, high disables
  input wire logic i_laser_fault, // Catastrophic laser fault detector
  input wire logic i_rx_signal_lost, // Receive signal loss from post-amplifier
  input wire logic [15:0] i_temp, // Live temperature reading
  input wire logic [15:0] i_vcc, // Live supply voltage reading
  input wire logic [15:0] i_bias, // Live laser bias reading
  input wire logic [15:0] i_tx_pwr, // Live transmit power reading
  input wire logic [15:0] i_rx_pwr, // Live receive power reading
  input wire logic i_id_wr, // Factory load strobe
  input wire logic [7:0] i_id_addr, // Factory load byte index
  input wire logic [7:0] i_id_data, // Factory load byte
  output logic o_laser_off, // Laser shut off
  output logic o_tx_fault_out, // Fault pin drive value, always low
  output logic o_tx_fault_oe_n, // Fault pin enable, high means fault
  output logic o_signal_lost_indication // Receive signal loss to host
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [omcs_pkg::PIN_COUNT-1:0] pin_vec;
  logic [omcs_pkg::PIN_COUNT-1:0] sync1;
  logic [omcs_pkg::PIN_COUNT-1:0] sync2;
  logic scl_q;
  logic sda_q;
  logic tx_dis_q;

  assign pin_vec = {i_rx_signal_lost, i_laser_fault, i_tx_disable, i_sda, i_scl};

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync1 <= omcs_pkg::PIN_SYNC_RST;
      sync2 <= omcs_pkg::PIN_SYNC_RST;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tx_dis_q <= 1'b1;
    end else if (i_clk_en) begin
      sync1 <= pin_vec;
      sync2 <= sync1;
      scl_q <= sync2[omcs_pkg::PIN_SCL];
      sda_q <= sync2[omcs_pkg::PIN_SDA];
      tx_dis_q <= sync2[omcs_pkg::PIN_TX_DIS];
    end
  end

  logic scl_s;
  logic sda_s;
  logic tx_dis_s;
  logic fault_s;
  logic rx_lost_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic tx_dis_fall;

  assign scl_s = sync2[omcs_pkg::PIN_SCL];
  assign sda_s = sync2[omcs_pkg::PIN_SDA];
  assign tx_dis_s = sync2[omcs_pkg::PIN_TX_DIS];
  assign fault_s = sync2[omcs_pkg::PIN_FAULT];
  assign rx_lost_s = sync2[omcs_pkg::PIN_RX_LOST];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;
  assign tx_dis_fall = tx_dis_q & ~tx_dis_s;

  // ----------------------------------------------------------------
  // Transmit control and fault latch
  // ----------------------------------------------------------------
  logic soft_dis;
  logic [3:0] ctrl_spare;
  logic fault_lat;
  logic next_fault_lat;
  logic next_laser_off;

  always_comb begin
    // latched until toggle
    // A fault still present on the clearing edge wins
    next_fault_lat = fault_s | (fault_lat & ~tx_dis_fall);
    next_laser_off = tx_dis_s | soft_dis | fault_lat;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_lat <= 1'b0;
      o_laser_off <= 1'b1;
      o_tx_fault_oe_n <= 1'b0;
      o_tx_fault_out <= 1'b0;
      o_signal_lost_indication <= 1'b0;
    end else if (i_clk_en) begin
      fault_lat <= next_fault_lat;
      o_laser_off <= next_laser_off;
      o_tx_fault_oe_n <= fault_lat;
      o_tx_fault_out <= 1'b0;
      o_signal_lost_indication <= rx_lost_s;
    end
  end

  // ----------------------------------------------------------------
  // Memories and read path
  // ----------------------------------------------------------------
  logic [7:0] id_mem [0:255];
  logic [7:0] diag_mem [0:255];
  logic [7:0] ctrl_byte;
  logic [7:0] rd_data;
  logic [7:0] ptr;
  logic diag_sel;

  assign ctrl_byte = {tx_dis_s, soft_dis, ctrl_spare[3:1], fault_lat, rx_lost_s, ctrl_spare[0]};

  always_comb begin
    rd_data = id_mem[ptr];
    if (diag_sel) begin
      case (ptr)
        omcs_pkg::ADDR_TEMP: rd_data = i_temp[15:8];
        omcs_pkg::ADDR_TEMP + 8'h01: rd_data = i_temp[7:0];
        omcs_pkg::ADDR_VCC: rd_data = i_vcc[15:8];
        omcs_pkg::ADDR_VCC + 8'h01: rd_data = i_vcc[7:0];
        omcs_pkg::ADDR_BIAS: rd_data = i_bias[15:8];
        omcs_pkg::ADDR_BIAS + 8'h01: rd_data = i_bias[7:0];
        omcs_pkg::ADDR_TX_PWR: rd_data = i_tx_pwr[15:8];
        omcs_pkg::ADDR_TX_PWR + 8'h01: rd_data = i_tx_pwr[7:0];
        omcs_pkg::ADDR_RX_PWR: rd_data = i_rx_pwr[15:8];
        omcs_pkg::ADDR_RX_PWR + 8'h01: rd_data = i_rx_pwr[7:0];
        omcs_pkg::ADDR_CTRL_STATUS: rd_data = ctrl_byte;
        default: rd_data = diag_mem[ptr];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  omcs_pkg::omcs_state_t state;
  omcs_pkg::omcs_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic next_diag_sel;
  logic next_sda_oe_n;
  logic next_soft_dis;
  logic [3:0] next_ctrl_spare;
  logic wr_en;
  logic dev_hit;

  assign dev_hit = (shift[7:1] == omcs_pkg::DEV_ID_AREA) || (shift[7:1] == omcs_pkg::DEV_DIAG_AREA);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_rw = rw;
    next_diag_sel = diag_sel;
    next_sda_oe_n = o_sda_oe_n;
    next_soft_dis = soft_dis;
    next_ctrl_spare = ctrl_spare;
    wr_en = 1'b0;
    if (bus_start) begin
      next_state = omcs_pkg::ST_DEV;
      next_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      next_state = omcs_pkg::ST_IDLE;
      next_sda_oe_n = 1'b1;
    end else begin
      case (state)
        omcs_pkg::ST_DEV, omcs_pkg::ST_WORD, omcs_pkg::ST_WDATA: begin
          if (scl_rise && cnt != omcs_pkg::BITS_PER_BYTE) begin
            next_shift = {shift[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == omcs_pkg::BITS_PER_BYTE) begin
            next_sda_oe_n = 1'b0;
            if (state == omcs_pkg::ST_DEV) begin
              next_state = dev_hit ? omcs_pkg::ST_DEV_ACK : omcs_pkg::ST_IDLE;
              next_sda_oe_n = ~dev_hit;
              next_rw = shift[0];
              next_diag_sel = (shift[7:1] == omcs_pkg::DEV_DIAG_AREA);
            end else if (state == omcs_pkg::ST_WORD) begin
              next_state = omcs_pkg::ST_WORD_ACK;
              next_ptr = shift;
            end else begin
              next_state = omcs_pkg::ST_WDATA_ACK;
              next_ptr = ptr + 8'h01;
              wr_en = diag_sel;
              if (diag_sel && ptr == omcs_pkg::ADDR_CTRL_STATUS) begin
                next_soft_dis = shift[omcs_pkg::BIT_SOFT_DIS];
                next_ctrl_spare = {shift[5:3], shift[0]};
              end
            end
          end
        end
        omcs_pkg::ST_DEV_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_state = omcs_pkg::ST_RDATA;
              next_shift = rd_data;
              next_sda_oe_n = rd_data[7];
            end else begin
              next_state = omcs_pkg::ST_WORD;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        omcs_pkg::ST_WORD_ACK, omcs_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_state = omcs_pkg::ST_WDATA;
            next_cnt = 4'h0;
            next_sda_oe_n = 1'b1;
          end
        end
        omcs_pkg::ST_RDATA: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == omcs_pkg::BITS_PER_BYTE) begin
            next_state = omcs_pkg::ST_RDATA_ACK;
            next_sda_oe_n = 1'b1;
            next_ptr = ptr + 8'h01;
          end else if (scl_fall) begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_oe_n = shift[6];
          end
        end
        omcs_pkg::ST_RDATA_ACK: begin
          if (scl_rise && sda_s) begin
            next_state = omcs_pkg::ST_IDLE;
          end else if (scl_fall) begin
            next_state = omcs_pkg::ST_RDATA;
            next_cnt = 4'h0;
            next_shift = rd_data;
            next_sda_oe_n = rd_data[7];
          end
        end
        default: begin
          next_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= omcs_pkg::ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      diag_sel <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
      soft_dis <= 1'b0;
      ctrl_spare <= omcs_pkg::CTRL_SPARE_RST;
    end else if (i_clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      rw <= next_rw;
      diag_sel <= next_diag_sel;
      o_sda_oe_n <= next_sda_oe_n;
      o_sda_out <= 1'b0;
      soft_dis <= next_soft_dis;
      ctrl_spare <= next_ctrl_spare;
    end
  end

  // Memories hold no reset; identification is loaded by the factory port
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && wr_en) begin
      diag_mem[ptr] <= shift;
    end
    if (i_clk_en && i_id_wr) begin
      id_mem[i_id_addr] <= i_id_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_laser_or_term: assert property (i_clk_en |=>
    o_laser_off == ($past(tx_dis_s) | $past(soft_dis) | $past(fault_lat)))
    else $error("laser off not the OR of its causes");
  chk_fault_sets: assert property (i_clk_en && fault_s |=> fault_lat ##1 (!i_clk_en || o_tx_fault_oe_n))
    else $error("fault did not latch onto the fault pin");
  chk_fault_holds: assert property (i_clk_en && fault_lat && !tx_dis_fall |=> fault_lat)
    else $error("fault latch dropped without a disable toggle");
  chk_fault_clears: assert property (i_clk_en && fault_lat && tx_dis_fall && !fault_s |=> !fault_lat)
    else $error("disable toggle did not clear the fault");
  chk_status_mirror: assert property (ctrl_byte[omcs_pkg::BIT_HW_DIS] == tx_dis_s &&
    ctrl_byte[omcs_pkg::BIT_FAULT] == fault_lat && ctrl_byte[omcs_pkg::BIT_RX_LOST] == rx_lost_s)
    else $error("status byte does not mirror hardware");
  chk_soft_write: assert property (i_clk_en && state == omcs_pkg::ST_WDATA && scl_fall && diag_sel &&
    cnt == omcs_pkg::BITS_PER_BYTE && ptr == omcs_pkg::ADDR_CTRL_STATUS && !bus_start && !bus_stop
    |=> soft_dis == $past(shift[omcs_pkg::BIT_SOFT_DIS]))
    else $error("soft disable bit not written");
  chk_dev_ack: assert property (i_clk_en && state == omcs_pkg::ST_DEV && scl_fall && dev_hit &&
    cnt == omcs_pkg::BITS_PER_BYTE && !bus_start && !bus_stop |=> !o_sda_oe_n && state == omcs_pkg::ST_DEV_ACK)
    else $error("matching device address not acknowledged");
  chk_test_nack: assert property (state == omcs_pkg::ST_DEV && shift[7:1] == omcs_pkg::DEV_TEST_AREA
    |=> o_sda_oe_n)
    else $error("reserved test page answered");
  chk_ctrl_read: assert property (i_clk_en && state == omcs_pkg::ST_DEV_ACK && scl_fall && rw && diag_sel &&
    ptr == omcs_pkg::ADDR_CTRL_STATUS && !bus_start && !bus_stop |=> shift == $past(ctrl_byte))
    else $error("control byte not loaded for read");

  cov_diag_ack: cover property (state == omcs_pkg::ST_DEV_ACK && diag_sel);
  cov_read_nack: cover property (state == omcs_pkg::ST_RDATA_ACK ##1 state == omcs_pkg::ST_IDLE);
  cov_fault_clear: cover property (fault_lat ##1 !fault_lat);
  cov_soft_dis: cover property (!soft_dis ##1 soft_dis);

endmodule // omcs_top

`default_nettype wire

// *** hw/omcs_pkg.sv ***
// Constants shared by the optical module control and status block.
// Assumes a 25 MHz system clock and a host-driven two-wire management bus.
`default_nettype none

package omcs_pkg;

  // ----------------------------------------------------------------
  // Two-wire device addresses (upper seven bits)
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ID_AREA = 7'h50;
  localparam logic [6:0] DEV_DIAG_AREA = 7'h51;
  localparam logic [6:0] DEV_TEST_AREA = 7'h58;

  // ----------------------------------------------------------------
  // Diagnostic area layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h6E;
  localparam logic [7:0] ADDR_TEMP = 8'h60;
  localparam logic [7:0] ADDR_VCC = 8'h62;
  localparam logic [7:0] ADDR_BIAS = 8'h64;
  localparam logic [7:0] ADDR_TX_PWR = 8'h66;
  localparam logic [7:0] ADDR_RX_PWR = 8'h68;
  localparam int BIT_HW_DIS = 7;
  localparam int BIT_SOFT_DIS = 6;
  localparam int BIT_FAULT = 2;
  localparam int BIT_RX_LOST = 1;
  localparam logic [3:0] CTRL_SPARE_RST = 4'h0;

  // ----------------------------------------------------------------
  // Pin synchroniser lanes and their reset levels
  // ----------------------------------------------------------------
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_TX_DIS = 2;
  localparam int PIN_FAULT = 3;
  localparam int PIN_RX_LOST = 4;
  localparam int PIN_COUNT = 5;
  // Bus idles high; disable input reads asserted until driven low
  localparam logic [4:0] PIN_SYNC_RST = 5'h07;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Host pacing of the disable input (kept by the host)
  // ----------------------------------------------------------------
  localparam int TX_DIS_SPACING_MS = 10;
  localparam int SYS_CLK_HZ = 25000000;
  localparam int TX_DIS_SPACING_CYC = TX_DIS_SPACING_MS * (SYS_CLK_HZ / 1000);

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WORD, ST_WORD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } omcs_state_t;

endpackage

`default_nettype wire

// *** dv/omcs_host_model.sv ***
// Host board model: master on the two-wire management bus.
// Assumes a pull-up on the data wire; the bus clock stands high outside frames.
`default_nettype none

module omcs_host_model (
  output logic o_scl, // Bus clock, high while idle
  output logic o_sda, // Data drive, 1 releases the wire
  input wire logic i_sda_wire // Resolved data wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of 320 ns, so each clock phase spans four system cycles
  localparam time QTR = 80ns;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bit and frame primitives
  // ----------------------------------------------------------------
  // Data moves mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    #QTR o_scl = 1'b1;
    #QTR r = i_sda_wire;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask

  task automatic start();
    o_sda = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    o_sda = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b1;
    #QTR;
  endtask

  task automatic byte_out(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask

  // Last byte of a read is refused, which ends the transfer
  task automatic byte_in(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // host sets control bits
  task automatic write(input logic [6:0] dev, input logic [7:0] addr, input logic [7:0] data, output logic ok);
    ok = 1'b1;
    start();
    byte_out({dev, 1'b0}, ok);
    byte_out(addr, ok);
    byte_out(data, ok);
    stop();
  endtask

  task automatic read(input logic [6:0] dev, input logic [7:0] addr, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    byte_out({dev, 1'b0}, ok);
    byte_out(addr, ok);
    start();
    byte_out({dev, 1'b1}, ok);
    byte_in(d);
    stop();
  endtask

  task automatic cur_read(input logic [6:0] dev, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    byte_out({dev, 1'b1}, ok);
    byte_in(d);
    stop();
  endtask
endmodule // omcs_host_model

`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the optical module control and status block.
// Assumes the host bus model beside it and pull-ups on the bus, fault and disable pins.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ID = omcs_pkg::DEV_ID_AREA;
  localparam logic [6:0] DIAG = omcs_pkg::DEV_DIAG_AREA;
  localparam logic [7:0] CTL = omcs_pkg::ADDR_CTRL_STATUS;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic laser_fault = 1'b0;
  logic rx_lost = 1'b0;
  logic tx_dis_en = 1'b0;
  logic id_wr = 1'b0;
  logic [7:0] id_addr = 8'h00;
  logic [7:0] id_data = 8'h00;
  logic [15:0] rdg [5] = '{default: 16'h0000};
  logic host_scl, host_sda, sda_out, sda_oe_n, laser_off, fault_out, fault_oe_n, lost;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  tri1 tx_dis_w;
  wire sda_w;
  wire fault_w;

  // Open-drain wires against their pull-ups; disable pin floats high
  assign sda_w = host_sda & (sda_oe_n | sda_out);
  assign fault_w = fault_oe_n | fault_out;
  assign tx_dis_w = tx_dis_en ? 1'b0 : 1'bz;

  omcs_host_model host (.o_scl(host_scl), .o_sda(host_sda), .i_sda_wire(sda_w));

  omcs_top dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_scl(host_scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_tx_disable(tx_dis_w), .i_laser_fault(laser_fault),
    .i_rx_signal_lost(rx_lost), .i_temp(rdg[0]), .i_vcc(rdg[1]), .i_bias(rdg[2]), .i_tx_pwr(rdg[3]),
    .i_rx_pwr(rdg[4]), .i_id_wr(id_wr), .i_id_addr(id_addr), .i_id_data(id_data), .o_laser_off(laser_off),
    .o_tx_fault_out(fault_out), .o_tx_fault_oe_n(fault_oe_n), .o_signal_lost_indication(lost)
  );

  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic get(input logic [6:0] dev, input logic [7:0] addr, output logic [7:0] d);
    logic ok;
    host.read(dev, addr, d, ok);
    check("read_ack", 8'h01, {7'h0, ok});
  endtask

  task automatic put(input logic [6:0] dev, input logic [7:0] addr, input logic [7:0] d);
    logic ok;
    host.write(dev, addr, d, ok);
    check("write_ack", 8'h01, {7'h0, ok});
  endtask

  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    id_wr <= 1'b1;
    id_addr <= a;
    id_data <= d;
    @(posedge sys_clk);
    id_wr <= 1'b0;
  endtask

  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    repeat (5) @(negedge sys_clk);
    check("laser_off", 8'h01, {7'h0, laser_off});
    check("fault_pin", 8'h00, {7'h0, fault_w});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h80, v);
  endtask

  // Fault cleared by pulling the floating disable pin low: one assertion only, no spacing due
  task automatic t_fault();
    logic [7:0] v;
    @(posedge sys_clk) laser_fault <= 1'b1;
    repeat (3) @(posedge sys_clk);
    laser_fault <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check("fault_pin", 8'h01, {7'h0, fault_w});
    check("laser_off", 8'h01, {7'h0, laser_off});
    repeat (100) @(negedge sys_clk);
    check("fault_held", 8'h01, {7'h0, fault_w});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h84, v);
    @(posedge sys_clk) tx_dis_en <= 1'b1;
    repeat (8) @(negedge sys_clk);
    check("fault_pin", 8'h00, {7'h0, fault_w});
    check("laser_off", 8'h00, {7'h0, laser_off});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h00, v);
  endtask

  task automatic t_soft();
    logic [7:0] v;
    put(DIAG, CTL, 8'hFF);
    repeat (4) @(negedge sys_clk);
    check("laser_off", 8'h01, {7'h0, laser_off});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h79, v);
    put(DIAG, CTL, 8'h00);
    repeat (4) @(negedge sys_clk);
    check("laser_off", 8'h00, {7'h0, laser_off});
  endtask

  task automatic t_rx_lost();
    logic [7:0] v;
    @(posedge sys_clk) rx_lost <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check("lost_ind", 8'h01, {7'h0, lost});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h02, v);
    @(posedge sys_clk) rx_lost <= 1'b0;
    repeat (6) @(negedge sys_clk);
    check("lost_ind", 8'h00, {7'h0, lost});
  endtask

  task automatic t_live();
    logic [7:0] v;
    @(posedge sys_clk) rdg <= '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718, 16'h293A};
    // Bus frames start off the sampling edge
    @(negedge sys_clk);
    for (int j = 0; j < 10; j++) begin
      get(DIAG, omcs_pkg::ADDR_TEMP + 8'(j), v);
      check("reading", j[0] ? rdg[j / 2][7:0] : rdg[j / 2][15:8], v);
    end
    @(posedge sys_clk) rdg[0] <= 16'h5A6B;
    @(negedge sys_clk);
    get(DIAG, omcs_pkg::ADDR_TEMP + 8'h01, v);
    check("refreshed", 8'h6B, v);
  endtask

  task automatic t_id();
    logic [7:0] v;
    logic ok;
    load(8'hFF, 8'h5A);
    load(8'h00, 8'hC3);
    @(negedge sys_clk);
    put(ID, 8'hFF, 8'h00);
    get(ID, 8'hFF, v);
    check("id_byte", 8'h5A, v);
    host.cur_read(ID, v, ok);
    check("cur_ack", 8'h01, {7'h0, ok});
    check("id_wrap", 8'hC3, v);
  endtask

  task automatic t_reserved();
    logic ok;
    host.write(omcs_pkg::DEV_TEST_AREA, 8'h00, 8'h00, ok);
    check("test_ack", 8'h00, {7'h0, ok});
  endtask

  // Enable low must freeze the status path
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    rx_lost <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check("frozen_lost", 8'h00, {7'h0, lost});
    @(posedge sys_clk) clk_en <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check("lost_ind", 8'h01, {7'h0, lost});
    @(posedge sys_clk) rx_lost <= 1'b0;
    repeat (6) @(negedge sys_clk);
    check("lost_ind", 8'h00, {7'h0, lost});
  endtask

  // Reset in mid-run clears the soft disable; pin held low throughout
  task automatic t_midreset();
    logic [7:0] v;
    put(DIAG, CTL, 8'h40);
    repeat (4) @(negedge sys_clk);
    check("laser_off", 8'h01, {7'h0, laser_off});
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check("laser_off", 8'h01, {7'h0, laser_off});
    check("fault_pin", 8'h00, {7'h0, fault_w});
    repeat (6) @(negedge sys_clk);
    check("laser_off", 8'h00, {7'h0, laser_off});
    get(DIAG, CTL, v);
    check("ctl_byte", 8'h00, v);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_fault();
    t_soft();
    t_rx_lost();
    t_live();
    t_id();
    t_reserved();
    t_freeze();
    t_midreset();
    final_report();
  end
endmodule // testbench

`default_nettype wire
